/* File: rtl/spn_servo_filter.sv */
// Servo position-loop filter: PID with feed-forward, then a second-order notch.
// Assumes position samples arrive as a valid/ready stream on aclk, one per servo
// cycle, and that the command word is taken by the DAC side with cmd_ready.
//
// Contract
// [R1] Command is scaled PID with velocity and acceleration feed-forward terms.
// [R2] Command word is 16-bit two's complement, -32768 to +32767.
// [R3] Command magnitude is clamped to the output limit setting.
// [R4] Following error is target minus measured position, same cycle.
// [R5] Measured velocity is measured position minus previous measured position.
// [R6] Target velocity is target position minus previous target position.
// [R7] Target acceleration is target velocity minus previous target velocity.
// [R8] Error sum holds earlier integrated errors, excluding the current one.
// [R9] Hold mode with moving target freezes the sum but still applies it.
// [R10] Notch is (1+n1 z^-1+n2 z^-2)/(1+d1 z^-1+d2 z^-2).
// [R11] Notch filters the PID result before the output.
// [R12] n1, n2, d1, d2 come from the four notch settings.
// [R13] Notch settings are the difference-equation multipliers directly.
// [R14] Notch coefficients are 24-bit signed, 21 fractional bits.
// [R15] Software normally sets the position gain factor to 96.
// [R16] Reset clears error sum, position and velocity history, notch states.
`timescale 1ns/1ps

module spn_fifo #(
  parameter int W = 64,
  parameter int DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [W-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [AW:0] count_reg, count_next;
  logic in_ready_reg;
  wire push = in_valid && in_ready_reg;
  wire pop = out_valid && out_ready;

  assign count_next = count_reg + (AW+1)'(push) - (AW+1)'(pop);
  assign in_ready = in_ready_reg;
  assign out_valid = (count_reg != '0);
  assign out_data = mem[rd_ptr_reg];

  always_ff @(posedge aclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  // Ready is registered from the next count so the source sees an honest full
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
      in_ready_reg <= 1'b0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + AW'(push);
      rd_ptr_reg <= rd_ptr_reg + AW'(pop);
      count_reg <= count_next;
      in_ready_reg <= (count_next < (AW+1)'(DEPTH));
    end
  end
endmodule : spn_fifo

module spn_servo_filter (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [spn_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [spn_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire spn_pkg::spn_sample_s smp_data,
  input wire logic smp_valid,
  output logic smp_ready,
  output logic [spn_pkg::OUT_W-1:0] motor_command_word,
  output logic cmd_valid,
  input wire logic cmd_ready
);
  import spn_pkg::*;

  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  logic [31:0] cfg_reg [NUM_CFG];
  logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
  logic arready_reg, rvalid_reg;
  logic [3:0] wr_idx_reg, wstrb_reg;
  logic [31:0] wdata_reg, rdata_reg, wr_merged;
  logic [1:0] bresp_reg, rresp_reg;

  wire aw_take = s_axi_awvalid && awready_reg;
  wire w_take = s_axi_wvalid && wready_reg;
  wire do_write = aw_full_reg && w_full_reg && !bvalid_reg;
  wire b_done = bvalid_reg && s_axi_bready;
  wire ar_take = s_axi_arvalid && arready_reg;
  wire r_done = rvalid_reg && s_axi_rready;
  wire wr_hit = (wr_idx_reg < 4'(NUM_CFG));
  wire [31:0] wr_old = wr_hit ? cfg_reg[wr_idx_reg] : 32'h0;
  wire [3:0] rd_idx = s_axi_araddr[ADDR_W-1:2];
  wire rd_cfg = (rd_idx < 4'(NUM_CFG));

  always_comb begin
    for (int b = 0; b < 4; b++) begin
      wr_merged[8*b +: 8] = wstrb_reg[b] ? wdata_reg[8*b +: 8] : wr_old[8*b +: 8];
    end
  end

  // Address and data may arrive in either order; the response waits for both
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      wr_idx_reg <= 4'h0;
      wdata_reg <= 32'h0;
      wstrb_reg <= 4'h0;
    end else begin
      if (aw_take) begin
        aw_full_reg <= 1'b1;
        awready_reg <= 1'b0;
        wr_idx_reg <= s_axi_awaddr[ADDR_W-1:2];
      end else if (b_done) begin
        aw_full_reg <= 1'b0;
        awready_reg <= 1'b1;
      end
      if (w_take) begin
        w_full_reg <= 1'b1;
        wready_reg <= 1'b0;
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
      end else if (b_done) begin
        w_full_reg <= 1'b0;
        wready_reg <= 1'b1;
      end
      if (do_write) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (b_done) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    for (int i = 0; i < NUM_CFG; i++) begin
      if (!aresetn) begin
        cfg_reg[i] <= CFG_RST[i];
      end else if (do_write && wr_idx_reg == 4'(i)) begin
        cfg_reg[i] <= wr_merged & CFG_MASK[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Settings
  // ----------------------------------------------------------------
  wire signed [GAIN_W-1:0] prop_gain = cfg_reg[IX_PROP][GAIN_W-1:0];
  wire signed [GAIN_W-1:0] deriv_gain = cfg_reg[IX_DERIV][GAIN_W-1:0];
  wire signed [GAIN_W-1:0] vel_ahead_gain = cfg_reg[IX_VFF][GAIN_W-1:0];
  wire signed [GAIN_W-1:0] integral_gain = cfg_reg[IX_INTEG][GAIN_W-1:0];
  wire integ_hold_mode = cfg_reg[IX_HOLD][0];
  wire signed [GAIN_W-1:0] accel_ahead_gain = cfg_reg[IX_AFF][GAIN_W-1:0];
  wire signed [GAIN_W-1:0] position_gain_factor = cfg_reg[IX_PGF][GAIN_W-1:0];
  wire signed [GAIN_W-1:0] velocity_gain_factor = cfg_reg[IX_VGF][GAIN_W-1:0];
  // [R12] Coefficient sources
  // [R14] Q2.21 coefficient format
  wire signed [COEF_W-1:0] notch_num_one = cfg_reg[IX_N1][COEF_W-1:0];
  wire signed [COEF_W-1:0] notch_num_two = cfg_reg[IX_N2][COEF_W-1:0];
  wire signed [COEF_W-1:0] notch_den_one = cfg_reg[IX_D1][COEF_W-1:0];
  wire signed [COEF_W-1:0] notch_den_two = cfg_reg[IX_D2][COEF_W-1:0];
  wire [OUT_W-1:0] output_limit = cfg_reg[IX_LIMIT][OUT_W-1:0];

  // ----------------------------------------------------------------
  // Sample buffer and error terms
  // ----------------------------------------------------------------
  logic [2*POS_W-1:0] fifo_data;
  logic fifo_valid;
  spn_state_e state_reg;
  spn_sample_s smp_q;
  logic signed [POS_W-1:0] prev_tgt_reg, prev_meas_reg, prev_cv_reg;
  logic signed [POS_W-1:0] fe_reg, av_reg, cv_reg, ca_reg;
  logic signed [INT_W-1:0] ie_reg, ie_use_reg;
  wire fifo_ready = (state_reg == ST_IDLE);
  wire pop = fifo_valid && fifo_ready;

  spn_fifo #(.W(2*POS_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_data(smp_data),
    .in_valid(smp_valid),
    .in_ready(smp_ready),
    .out_data(fifo_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready)
  );

  assign smp_q = fifo_data;
  // [R4] Following error
  wire signed [POS_W-1:0] fe_now = smp_q.target - smp_q.measured;
  // [R5] Measured velocity
  wire signed [POS_W-1:0] av_now = smp_q.measured - prev_meas_reg;
  // [R6] Target velocity
  wire signed [POS_W-1:0] cv_now = smp_q.target - prev_tgt_reg;
  // [R7] Target acceleration
  wire signed [POS_W-1:0] ca_now = cv_now - prev_cv_reg;
  // [R9] Integrator input gate
  wire integ_on = !(integ_hold_mode && cv_now != '0);

  // ----------------------------------------------------------------
  // PID law and notch, wide signed math to avoid intermediate overflow
  // ----------------------------------------------------------------
  function automatic logic signed [POS_W-1:0] spn_sat(input logic signed [WIDE_W-1:0] v);
    if (v > SAT_HI) begin
      return SAT_HI[POS_W-1:0];
    end else if (v < SAT_LO) begin
      return SAT_LO[POS_W-1:0];
    end
    return v[POS_W-1:0];
  endfunction : spn_sat

  logic signed [POS_W-1:0] x_reg, x1_reg, x2_reg, y1_reg, y2_reg;
  // [R1] Feed-forward and integral terms inside the position bracket
  wire signed [WIDE_W-1:0] ff_term = (WIDE_W'(vel_ahead_gain) * WIDE_W'(cv_reg)
    + WIDE_W'(accel_ahead_gain) * WIDE_W'(ca_reg)) >>> FF_SHIFT;
  wire signed [WIDE_W-1:0] int_term = (WIDE_W'(integral_gain) * WIDE_W'(ie_use_reg))
    >>> INT_SHIFT;
  wire signed [WIDE_W-1:0] damp_term = (WIDE_W'(deriv_gain) * WIDE_W'(velocity_gain_factor)
    * WIDE_W'(av_reg)) >>> FF_SHIFT;
  wire signed [WIDE_W-1:0] inner = WIDE_W'(position_gain_factor)
    * (WIDE_W'(fe_reg) + ff_term + int_term) - damp_term;
  wire signed [WIDE_W-1:0] pid_full = (WIDE_W'(prop_gain) * inner) >>> OUT_SHIFT;

  // [R10] Direct-form difference equation
  // [R13] Settings used as multipliers unchanged
  wire signed [WIDE_W-1:0] notch_acc = (WIDE_W'(x_reg) <<< COEF_FRAC)
    + WIDE_W'(notch_num_one) * WIDE_W'(x1_reg) + WIDE_W'(notch_num_two) * WIDE_W'(x2_reg)
    - WIDE_W'(notch_den_one) * WIDE_W'(y1_reg) - WIDE_W'(notch_den_two) * WIDE_W'(y2_reg);
  wire signed [POS_W-1:0] y_now = spn_sat(notch_acc >>> COEF_FRAC);

  // Limits above full scale fold back to full scale
  wire [OUT_W-1:0] lim_eff = output_limit[OUT_W-1] ? CMD_MAX : output_limit;
  wire signed [POS_W-1:0] lim_pos = POS_W'(lim_eff);
  wire signed [POS_W-1:0] lim_neg = -lim_pos;
  // [R3] Magnitude clamp
  // [R2] Signed 16-bit word
  wire [OUT_W-1:0] cmd_clamped = (y_now > lim_pos) ? lim_pos[OUT_W-1:0] :
    (y_now < lim_neg) ? lim_neg[OUT_W-1:0] : y_now[OUT_W-1:0];

  // ----------------------------------------------------------------
  // Servo cycle sequencer
  // ----------------------------------------------------------------
  logic [OUT_W-1:0] cmd_reg;
  logic cmd_valid_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      // [R16] History cleared on reset
      prev_tgt_reg <= '0;
      prev_meas_reg <= '0;
      prev_cv_reg <= '0;
      ie_reg <= '0;
      ie_use_reg <= '0;
      x1_reg <= '0;
      x2_reg <= '0;
      y1_reg <= '0;
      y2_reg <= '0;
      x_reg <= '0;
      fe_reg <= '0;
      av_reg <= '0;
      cv_reg <= '0;
      ca_reg <= '0;
      cmd_reg <= '0;
      cmd_valid_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (pop) begin
            fe_reg <= fe_now;
            av_reg <= av_now;
            cv_reg <= cv_now;
            ca_reg <= ca_now;
            prev_tgt_reg <= smp_q.target;
            prev_meas_reg <= smp_q.measured;
            prev_cv_reg <= cv_now;
            // [R8] Sum used now excludes this cycle's error
            ie_use_reg <= ie_reg;
            ie_reg <= integ_on ? ie_reg + INT_W'(fe_now) : ie_reg;
            state_reg <= ST_PID;
          end
        end
        ST_PID: begin
          x_reg <= spn_sat(pid_full);
          state_reg <= ST_NOTCH;
        end
        ST_NOTCH: begin
          // [R11] Notch sits between PID and the output word
          x1_reg <= x_reg;
          x2_reg <= x1_reg;
          y1_reg <= y_now;
          y2_reg <= y1_reg;
          cmd_reg <= cmd_clamped;
          cmd_valid_reg <= 1'b1;
          state_reg <= ST_OUT;
        end
        ST_OUT: begin
          if (cmd_ready) begin
            cmd_valid_reg <= 1'b0;
            state_reg <= ST_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  wire [31:0] rd_word = rd_cfg ? cfg_reg[rd_idx] :
    (rd_idx == IX_CMD) ? {{(32-OUT_W){cmd_reg[OUT_W-1]}}, cmd_reg} :
    (rd_idx == IX_SUM) ? ie_reg[31:0] : fe_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= RESP_OKAY;
    end else if (ar_take) begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_word;
      rresp_reg <= RESP_OKAY;
    end else if (r_done) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign motor_command_word = cmd_reg;
  assign cmd_valid = cmd_valid_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_follow_error: assert property (pop |=> fe_reg == $past(smp_q.target) - $past(smp_q.measured))  // [R4]
    else $error("following error not target minus measured");
  a_meas_velocity: assert property (pop |=> av_reg == $past(smp_q.measured) - $past(prev_meas_reg))  // [R5]
    else $error("measured velocity wrong");
  a_target_velocity: assert property (pop |=> cv_reg == $past(smp_q.target) - $past(prev_tgt_reg))  // [R6]
    else $error("target velocity wrong");
  a_target_accel: assert property (pop |=> ca_reg == cv_reg - $past(prev_cv_reg))  // [R7]
    else $error("target acceleration wrong");
  a_sum_excludes: assert property (pop |=> ie_use_reg == $past(ie_reg))  // [R8]
    else $error("integral used includes current error");
  a_integ_hold: assert property (pop && integ_hold_mode && cv_now != '0 |=> $stable(ie_reg))  // [R9]
    else $error("integral grew during hold");
  a_integ_add: assert property (pop && !integ_hold_mode |=> ie_reg == $past(ie_reg) + INT_W'(fe_reg))  // [R8]
    else $error("integral did not add error");
  a_out_limit: assert property (cmd_valid_reg |-> $signed(cmd_reg) <= $signed(lim_pos) && $signed(cmd_reg) >= $signed(lim_neg))  // [R3]
    else $error("command exceeds limit");
  a_notch_delay: assert property (state_reg == ST_NOTCH |=> x1_reg == $past(x_reg) && x2_reg == $past(x1_reg))  // [R10]
    else $error("notch delay line did not shift");
  a_cmd_latency: assert property (pop |-> ##3 cmd_valid_reg ##0 $rose(cmd_valid_reg))  // [R11]
    else $error("command not produced three cycles after sample");
  a_reset_clear: assert property (disable iff (1'b0) !aresetn |=> ie_reg == '0 && prev_meas_reg == '0 && y1_reg == '0)  // [R16]
    else $error("state not cleared by reset");

  c_sample_done: cover property (pop ##3 cmd_valid_reg ##1 cmd_ready);
  c_hold_freeze: cover property (pop && integ_hold_mode && cv_now != '0);
  c_limit_hit: cover property (state_reg == ST_NOTCH && y_now > lim_pos);
  c_fifo_full: cover property (smp_valid && !smp_ready);
endmodule : spn_servo_filter

/* File: shared/spn_pkg.sv */
// Constants, register map and carrier types for the servo PID and notch filter.
// Assumes a single 50 MHz clock domain and a 32-bit AXI4-Lite register bus.
package spn_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int POS_W = 32;
  localparam int GAIN_W = 24;
  localparam int COEF_W = 24;
  localparam int COEF_FRAC = 21;
  localparam int OUT_W = 16;
  localparam int INT_W = 48;
  localparam int WIDE_W = 96;
  localparam int ADDR_W = 6;
  localparam int FIFO_DEPTH = 16;

  // ----------------------------------------------------------------
  // Scaling shifts of the control law
  // ----------------------------------------------------------------
  localparam int FF_SHIFT = 7;
  localparam int INT_SHIFT = 23;
  localparam int OUT_SHIFT = 19;
  localparam logic signed [WIDE_W-1:0] SAT_HI = 96'sh0000_0000_0000_0000_7fff_ffff;
  localparam logic signed [WIDE_W-1:0] SAT_LO = -SAT_HI - 96'sh1;
  localparam logic [OUT_W-1:0] CMD_MAX = 16'h7fff;

  // ----------------------------------------------------------------
  // Register word indices (byte address = index * 4)
  // ----------------------------------------------------------------
  localparam int NUM_CFG = 13;
  localparam logic [3:0] IX_PROP = 4'h0;
  localparam logic [3:0] IX_DERIV = 4'h1;
  localparam logic [3:0] IX_VFF = 4'h2;
  localparam logic [3:0] IX_INTEG = 4'h3;
  localparam logic [3:0] IX_HOLD = 4'h4;
  localparam logic [3:0] IX_AFF = 4'h5;
  localparam logic [3:0] IX_PGF = 4'h6;
  localparam logic [3:0] IX_VGF = 4'h7;
  localparam logic [3:0] IX_N1 = 4'h8;
  localparam logic [3:0] IX_N2 = 4'h9;
  localparam logic [3:0] IX_D1 = 4'ha;
  localparam logic [3:0] IX_D2 = 4'hb;
  localparam logic [3:0] IX_LIMIT = 4'hc;
  localparam logic [3:0] IX_CMD = 4'hd;
  localparam logic [3:0] IX_SUM = 4'he;
  localparam logic [3:0] IX_FERR = 4'hf;
  localparam logic [31:0] CFG_MASK [NUM_CFG] = '{
    32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff, 32'h0000_0001,
    32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff, 32'h00ff_ffff,
    32'h00ff_ffff, 32'h00ff_ffff, 32'h0000_ffff};
  localparam logic [31:0] CFG_RST [NUM_CFG] = '{
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0060, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_7fff};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic signed [POS_W-1:0] target;
    logic signed [POS_W-1:0] measured;
  } spn_sample_s;

  typedef enum logic [1:0] {ST_IDLE, ST_PID, ST_NOTCH, ST_OUT} spn_state_e;

endpackage : spn_pkg

/* File: verification/spn_dac_model.sv */
// Converter side of the command stream: accepts words with a random ready.
// Assumes the bench holds stall high to block the stream for FIFO tests.
`timescale 1ns/1ps

module spn_dac_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] motor_command_word,
  input wire logic cmd_valid,
  input wire logic stall,
  output logic cmd_ready,
  output logic signed [15:0] dac_level
);
  integer seed = 32'h330a41a4;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_ready <= 1'b0;
      dac_level <= 16'sh0;
    end else begin
      // Slow and prompt acceptance both occur
      cmd_ready <= !stall && ($random(seed) % 4 != 0);
      // Signed word maps onto the output level
      if (cmd_valid && cmd_ready) begin
        dac_level <= $signed(motor_command_word);
      end
    end
  end
endmodule : spn_dac_model

/* File: verification/spn_servo_filter_tb.sv */
// Self-checking bench for the servo filter: registers over AXI4-Lite,
// random position stream in, command words checked against a model.
`timescale 1ns/1ps

module spn_servo_filter_tb;
  import spn_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid, smp_ready, cmd_valid, cmd_ready;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] word;
  spn_sample_s smp = '0;
  logic smp_valid = 1'b0, stall = 1'b0, full_seen = 1'b0;
  integer seed = 32'h330a41a4;
  int errors = 0, compares = 0, cyc = 0;
  logic [31:0] g [NUM_CFG];
  logic [15:0] exp_q [$];
  logic signed [95:0] tp, mp, cvp, x1, x2, y1, y2, lfe;
  logic signed [47:0] ie;

  always #10 aclk = ~aclk;

  spn_servo_filter i_spn_servo_filter (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .smp_data(smp), .smp_valid(smp_valid), .smp_ready(smp_ready),
    .motor_command_word(word), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready));

  spn_dac_model i_spn_dac_model (.aclk(aclk), .aresetn(aresetn), .motor_command_word(word),
    .cmd_valid(cmd_valid), .stall(stall), .cmd_ready(cmd_ready), .dac_level());

  task automatic print_verdict;
    if (errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [3:0] ix, input logic [31:0] d, output logic [1:0] r);
    awaddr <= {ix, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask : axi_write

  task automatic axi_read(input logic [3:0] ix, output logic [31:0] d);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    chk(32'(rresp), 32'(RESP_OKAY));
    rready <= 1'b0;
    @(posedge aclk);
  endtask : axi_read

  function automatic logic signed [95:0] sg(input logic [31:0] v);
    return $signed({{72{v[23]}}, v[23:0]});
  endfunction : sg

  function automatic logic signed [95:0] sat(input logic signed [95:0] v);
    return (v > SAT_HI) ? SAT_HI : ((v < SAT_LO) ? SAT_LO : v);
  endfunction : sat

  function automatic logic [15:0] model(input logic signed [31:0] t, input logic signed [31:0] m);
    logic signed [95:0] fe, cv, av, ca, x, y, lim;
    fe = t - m;
    cv = t - tp;
    av = m - mp;
    ca = cv - cvp;
    x = sg(g[0]) * (sg(g[6]) * (fe + ((sg(g[2]) * cv + sg(g[5]) * ca) >>> 7)
        + ((sg(g[3]) * ie) >>> 23)) - ((sg(g[1]) * sg(g[7]) * av) >>> 7));
    x = sat(x >>> 19);
    y = sat(((x <<< 21) + sg(g[8]) * x1 + sg(g[9]) * x2 - sg(g[10]) * y1 - sg(g[11]) * y2) >>> 21);
    if (!(g[4][0] && cv != 0)) ie = ie + fe;
    // Positions are 32 bits: assign them alone so they sign-extend into the history
    tp = t;
    mp = m;
    {cvp, x2, x1, y2, y1, lfe} = {cv, x1, x, y1, y, fe};
    lim = g[12][15] ? 96'sh7fff : $signed({80'h0, g[12][15:0]});
    return (y > lim) ? lim[15:0] : ((y < -lim) ? 16'(-lim) : y[15:0]);
  endfunction : model

  task automatic send(input logic signed [31:0] t, input logic signed [31:0] m);
    smp <= '{target: t, measured: m};
    smp_valid <= 1'b1;
    exp_q.push_back(model(t, m));
    forever begin
      @(posedge aclk);
      if (smp_ready) break;
    end
  endtask : send

  // ----------------------------------------------------------------
  // Checks on the command stream
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc++;
    if (smp_valid && !smp_ready) full_seen = 1'b1;
    if (aresetn && cmd_valid && cmd_ready) begin
      if (exp_q.size() == 0) chk(32'(word), 32'hffff_ffff);
      else chk(32'(word), 32'(exp_q.pop_front()));
    end
    if (cyc == 20000) begin
      errors++;
      print_verdict();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, v;
    logic [1:0] r;
    logic signed [31:0] t, m;
    for (int p = 0; p < 2; p++) begin
      aresetn <= 1'b0;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      {tp, mp, cvp, x1, x2, y1, y2, ie, lfe} = '0;
      @(posedge aclk);
      for (int i = 0; i < 14; i++) begin
        axi_read(4'(i), d);
        chk(d, (i == 6) ? 32'h60 : ((i == 12) ? 32'h7fff : 32'h0));
      end
      for (int i = 0; i < NUM_CFG; i++) begin
        v = (i < 8) ? $random(seed) % 32768 : $random(seed) % 2097152;
        if (i == 4) v = p;
        if (i == 6) v = 32'h60;
        // Second pass sets a limit above full scale, which must act as full scale
        if (i == 12) v = p ? 32'h0000_ffff : 32'h0800 + ($random(seed) & 32'hfff);
        axi_write(4'(i), v, r);
        chk(32'(r), 32'(RESP_OKAY));
        g[i] = v & CFG_MASK[i];
        axi_read(4'(i), d);
        chk(d, g[i]);
      end
      axi_write(4'hd, 32'h1234, r);
      chk(32'(r), 32'(RESP_SLVERR));
      full_seen = 1'b0;
      stall <= 1'b1;
      fork
        begin
          repeat (150) @(posedge aclk);
          stall <= 1'b0;
        end
      join_none
      t = $random(seed) % 32768;
      m = t;
      for (int k = 0; k < 48; k++) begin
        if (k % 5 != 0) t = t + $random(seed) % 4096;
        m = m + $random(seed) % 2048;
        send(t, m);
      end
      smp_valid <= 1'b0;
      for (int k = 0; k < 3000 && exp_q.size() != 0; k++) @(posedge aclk);
      chk(32'(exp_q.size()), 32'h0);
      chk(32'(full_seen), 32'h1);
      axi_read(4'he, d);
      chk(d, ie[31:0]);
      axi_read(4'hf, d);
      chk(d, lfe[31:0]);
    end
    print_verdict();
  end
endmodule : spn_servo_filter_tb
